// *** inc/comparator_control_defs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef COMPARATOR_CONTROL_DEFS_SVH
`define COMPARATOR_CONTROL_DEFS_SVH

`define CTRL_OFFSET 4'h0
`define MUX_OFFSET 4'h2
`define INTEN_OFFSET 4'h6
`define STATUS_OFFSET 4'h7
`define SLEEP_OFFSET 4'h8

`define CTRL_ENABLE_BIT 0
`define CTRL_HYS_LSB 1
`define CTRL_LOWPOWER_BIT 3
`define CTRL_EDGE_LSB 4
`define CTRL_PADOUT_BIT 6
`define CTRL_STANDBY_BIT 7
`define MUX_NEG_LSB 0
`define MUX_POS_BIT 3
`define MUX_INVERT_BIT 7
`define INTEN_BIT 0
`define STATUS_FLAG_BIT 0
`define STATUS_STATE_BIT 4

`define CTRL_RESET 8'h00
`define MUX_RESET 8'h00

`define STARTUP_NS 2500
`define CLK_PERIOD_NS 10
`define STARTUP_CYCLES ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VREF_STARTUP_NS 60000
`define VREF_STARTUP_CYCLES ((`VREF_STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** inc/comparator_control_pkg.sv ***
// Types shared by the comparator control logic
package comparator_control_pkg;

    typedef enum logic [1:0] {
        EDGE_BOTH = 2'h0,
        EDGE_RSVD = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_RISE = 2'h3
    } edge_mode_e;

    typedef enum logic [1:0] {
        SLEEP_ACTIVE = 2'h0,
        SLEEP_IDLE = 2'h1,
        SLEEP_STANDBY = 2'h2,
        SLEEP_POWERDOWN = 2'h3
    } sleep_mode_e;

    typedef struct packed {
        logic enable;
        logic [1:0] hysteresis_select;
        logic low_power_select;
        logic [1:0] edge_interrupt_select;
        logic pad_output_enable;
        logic standby_run;
    } ctrl_s;

    typedef struct packed {
        logic invert;
        logic positive_input_select;
        logic [1:0] negative_input_select;
    } mux_s;

endpackage : comparator_control_pkg

// *** rtl/comparator_control.sv ***
// Comparator control logic with AXI4-Lite register slave
`timescale 1ns/1ps
`include "comparator_control_defs.svh"

module comparator_control
    import comparator_control_pkg::*;
(
    input wire logic clk_i, // Peripheral clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] awaddr, // Write address
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write strobes
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    output logic [1:0] bresp, // Write response
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    input wire logic [31:0] araddr, // Read address
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    input wire logic pos_pin_0_gt_neg_pin_0_i, // Analog pin comparisons
    input wire logic pos_pin_0_gt_neg_pin_1_i, // ...
    input wire logic pos_pin_0_gt_vref_i, // ...
    input wire logic pos_pin_0_gt_dac_i, // ...
    input wire logic pos_pin_1_gt_neg_pin_0_i, // ...
    input wire logic pos_pin_1_gt_neg_pin_1_i, // ...
    input wire logic pos_pin_1_gt_vref_i, // ...
    input wire logic pos_pin_1_gt_dac_i, // ...
    input wire logic [1:0] sleep_mode_i, // Sleep mode, sleep_mode_e
    input wire logic clk_requested_i, // Another module keeps clock in standby
    output logic analog_enable_o, // Comparator powered
    output logic positive_input_select_o, // Positive mux select
    output logic [1:0] negative_input_select_o, // Negative mux select
    output logic [1:0] hysteresis_select_o, // Hysteresis level
    output logic low_power_select_o, // Low-power mode
    output logic result_valid_o, // Start-up elapsed
    output logic event_o, // Event system output
    output logic pad_out_o, // Pad output value
    output logic pad_oe_o, // Pad output enable
    output logic irq_o // Interrupt request, comparator_vector
);
    localparam int STARTUP_W = 9;
    localparam logic [STARTUP_W-1:0] STARTUP_LAST = STARTUP_W'(`STARTUP_CYCLES);

    ctrl_s ctrl_q;
    mux_s mux_q;
    logic inten_q;
    logic flag_q;
    logic sync1_q, sync2_q, state_q, prev_q;
    logic [STARTUP_W-1:0] startup_q;
    logic aw_held_q, w_held_q;
    logic [3:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Raw comparison for the selected pair; the analog front end does the subtraction
    function automatic logic pick_raw(input logic pos, input logic [1:0] neg,
                                      input logic [7:0] cmp);
        pick_raw = cmp[{pos, neg}];
    endfunction : pick_raw

    function automatic logic [3:0] word_index(input logic [31:0] addr);
        word_index = addr[5:2];
    endfunction : word_index

    sleep_mode_e sleep;
    logic run_analog, clock_live, raw, result;
    assign sleep = sleep_mode_e'(sleep_mode_i);
    // Idle sleep is treated as active
    assign run_analog = ctrl_q.enable && (sleep == SLEEP_ACTIVE || sleep == SLEEP_IDLE ||
                        (sleep == SLEEP_STANDBY && ctrl_q.standby_run));
    // Status path frozen in standby unless someone else keeps the clock
    assign clock_live = sleep != SLEEP_STANDBY || clk_requested_i;
    assign raw = pick_raw(mux_q.positive_input_select, mux_q.negative_input_select,
                          {pos_pin_1_gt_dac_i, pos_pin_1_gt_vref_i, pos_pin_1_gt_neg_pin_1_i,
                           pos_pin_1_gt_neg_pin_0_i, pos_pin_0_gt_dac_i, pos_pin_0_gt_vref_i,
                           pos_pin_0_gt_neg_pin_1_i, pos_pin_0_gt_neg_pin_0_i});
    assign result = run_analog & (raw ^ mux_q.invert);

    // Analog control outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            analog_enable_o <= 1'b0;
            positive_input_select_o <= 1'b0;
            negative_input_select_o <= 2'h0;
            hysteresis_select_o <= 2'h0;
            low_power_select_o <= 1'b0;
        end else begin
            analog_enable_o <= run_analog;
            positive_input_select_o <= mux_q.positive_input_select;
            negative_input_select_o <= mux_q.negative_input_select;
            hysteresis_select_o <= ctrl_q.hysteresis_select;
            low_power_select_o <= ctrl_q.low_power_select;
        end
    end

    // Event and pad outputs keep running in standby with standby run
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_o <= 1'b0;
            pad_out_o <= 1'b0;
            pad_oe_o <= 1'b0;
        end else begin
            event_o <= result;
            pad_out_o <= ctrl_q.pad_output_enable & result;
            pad_oe_o <= ctrl_q.pad_output_enable & run_analog;
        end
    end

    // Start-up counter; restarts whenever the comparator is powered off
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            startup_q <= '0;
            result_valid_o <= 1'b0;
        end else if (!run_analog) begin
            startup_q <= '0;
            result_valid_o <= 1'b0;
        end else if (startup_q != STARTUP_LAST) begin
            startup_q <= startup_q + STARTUP_W'(1);
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= 1'b1;
        end
    end

    // Two-stage synchroniser, then the readable state bit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            state_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (clock_live) begin
            sync1_q <= result;
            sync2_q <= sync1_q;
            state_q <= sync2_q;
            prev_q <= state_q;
        end
    end

    logic edge_hit;
    always_comb begin
        unique case (edge_mode_e'(ctrl_q.edge_interrupt_select))
            EDGE_BOTH: edge_hit = state_q ^ prev_q;
            EDGE_FALL: edge_hit = prev_q & ~state_q;
            EDGE_RISE: edge_hit = state_q & ~prev_q;
            default: edge_hit = 1'b0;
        endcase
    end

    // AXI4-Lite write path
    logic wr_fire, wr_status, wr_clear;
    assign wr_fire = aw_held_q && w_held_q && !bvalid;
    assign wr_status = wr_fire && aw_idx_q == `STATUS_OFFSET && wstrb_q[0];
    assign wr_clear = wr_status && wdata_q[`STATUS_FLAG_BIT];

    // Flag: a set in the same cycle as a clear wins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_q <= 1'b0;
        end else if (clock_live && run_analog && edge_hit) begin
            flag_q <= 1'b1;
        end else if (wr_clear) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= inten_q & flag_q;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                aw_idx_q <= word_index(awaddr);
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid <= 1'b1;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    assign awready = !aw_held_q && !bvalid;
    assign wready = !w_held_q && !bvalid;
    assign bresp = 2'h0;

    // Configuration registers; software sets enable last
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= ctrl_s'(`CTRL_RESET);
            mux_q <= mux_s'(4'h0);
            inten_q <= 1'b0;
        end else if (wr_fire && wstrb_q[0]) begin
            unique case (aw_idx_q)
                `CTRL_OFFSET: begin
                    ctrl_q.enable <= wdata_q[`CTRL_ENABLE_BIT];
                    ctrl_q.hysteresis_select <= wdata_q[`CTRL_HYS_LSB +: 2];
                    ctrl_q.low_power_select <= wdata_q[`CTRL_LOWPOWER_BIT];
                    ctrl_q.edge_interrupt_select <= wdata_q[`CTRL_EDGE_LSB +: 2];
                    ctrl_q.pad_output_enable <= wdata_q[`CTRL_PADOUT_BIT];
                    ctrl_q.standby_run <= wdata_q[`CTRL_STANDBY_BIT];
                end
                `MUX_OFFSET: begin
                    mux_q.invert <= wdata_q[`MUX_INVERT_BIT];
                    mux_q.positive_input_select <= wdata_q[`MUX_POS_BIT];
                    mux_q.negative_input_select <= wdata_q[`MUX_NEG_LSB +: 2];
                end
                `INTEN_OFFSET: inten_q <= wdata_q[`INTEN_BIT];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read path, one cycle from address to data
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0;
        unique case (word_index(araddr))
            `CTRL_OFFSET: rd_word[7:0] = {ctrl_q.standby_run, ctrl_q.pad_output_enable,
                                          ctrl_q.edge_interrupt_select,
                                          ctrl_q.low_power_select,
                                          ctrl_q.hysteresis_select, ctrl_q.enable};
            `MUX_OFFSET: rd_word[7:0] = {mux_q.invert, 3'h0, mux_q.positive_input_select,
                                         1'b0, mux_q.negative_input_select};
            `INTEN_OFFSET: rd_word[`INTEN_BIT] = inten_q;
            `STATUS_OFFSET: begin
                rd_word[`STATUS_FLAG_BIT] = flag_q;
                rd_word[`STATUS_STATE_BIT] = state_q;
            end
            `SLEEP_OFFSET: rd_word[0] = result_valid_o;
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
    assign arready = !rvalid;
    assign rresp = 2'h0;

    // Checks
    flag_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clock_live && run_analog && edge_hit |=> flag_q) else $error("flag not set");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_clear && !(clock_live && run_analog && edge_hit) |=> !flag_q)
        else $error("flag not cleared");
    irq_pair_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_o == $past(inten_q & flag_q)) else $error("irq mismatch");
    // Flag must not drop by itself, so the request keeps standing
    irq_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_o && inten_q && flag_q && !wr_clear |=> irq_o && flag_q)
        else $error("irq dropped");
    // Every stage must have been clocked for the lag to hold
    state_lag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $past(clock_live) && $past(clock_live, 2) && $past(clock_live, 3)
        |-> state_q == $past(result, 3)) else $error("state lag");
    pad_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pad_out_o |-> $past(ctrl_q.pad_output_enable)) else $error("pad leak");
    event_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        event_o == $past(result)) else $error("event mismatch");
    powerdown_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sleep == SLEEP_POWERDOWN |=> !analog_enable_o && !pad_oe_o)
        else $error("powerdown active");
    startup_wait_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(run_analog) |=> !result_valid_o [*8]) else $error("early valid");
    reserved_edge_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ctrl_q.edge_interrupt_select == 2'h1 && !flag_q && !wr_fire |=> !flag_q)
        else $error("reserved mode fired");
    irq_seen_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(irq_o));
    clear_seen_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) wr_clear);
    standby_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        sleep == SLEEP_STANDBY && event_o);
endmodule : comparator_control

// *** tb/comparator_control_test.sv ***
// Self-checking bench for the comparator control logic
`timescale 1ns/1ps
`include "comparator_control_defs.svh"

module comparator_control_test
    import comparator_control_pkg::*;
;
    localparam logic [31:0] A_CTRL = 32'(`CTRL_OFFSET) << 2;
    localparam logic [31:0] A_MUX = 32'(`MUX_OFFSET) << 2;
    localparam logic [31:0] A_INTEN = 32'(`INTEN_OFFSET) << 2;
    localparam logic [31:0] A_STAT = 32'(`STATUS_OFFSET) << 2;
    localparam logic [31:0] A_NONE = 32'h0000_0014;
    localparam int CEILING = 20000;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    // Pins reach the block only as comparison bits; no digital input path is used
    logic [7:0] cmp_in = 8'h00;
    logic [1:0] sleep_mode = 2'h0;
    logic clk_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, neg_sel, hys_sel;
    logic ana_en, pos_sel, lp_sel, res_valid, ev, pad_out, pad_oe, irq;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    edge_mode_e md [4] = '{EDGE_BOTH, EDGE_FALL, EDGE_RISE, EDGE_RSVD};

    comparator_control u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .pos_pin_0_gt_neg_pin_0_i(cmp_in[0]), .pos_pin_0_gt_neg_pin_1_i(cmp_in[1]),
        .pos_pin_0_gt_vref_i(cmp_in[2]), .pos_pin_0_gt_dac_i(cmp_in[3]),
        .pos_pin_1_gt_neg_pin_0_i(cmp_in[4]), .pos_pin_1_gt_neg_pin_1_i(cmp_in[5]),
        .pos_pin_1_gt_vref_i(cmp_in[6]), .pos_pin_1_gt_dac_i(cmp_in[7]),
        .sleep_mode_i(sleep_mode), .clk_requested_i(clk_req),
        .analog_enable_o(ana_en), .positive_input_select_o(pos_sel),
        .negative_input_select_o(neg_sel), .hysteresis_select_o(hys_sel),
        .low_power_select_o(lp_sel), .result_valid_o(res_valid), .event_o(ev),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .irq_o(irq)
    );

    always #5 clk_i = ~clk_i;

    task automatic wrap_up();
        $display("Counts: %0d mismatches in %0d checks", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // A hang anywhere ends here as a mismatch
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            errors = errors + 1;
            $display("Error at %0t: timeout", $time);
            wrap_up();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                check_word(32'(bresp), 32'h0, "write response");
            end
        end
    endtask : bus_write

    task automatic read_check(input logic [31:0] a, input logic [31:0] exp);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                check_word(rdata, exp, "read data");
                check_word(32'(rresp), 32'h0, "read response");
            end
        end
    endtask : read_check

    // Inputs change by NBA right after an edge
    task automatic set_in(input logic [7:0] v, input sleep_mode_e s, input logic r);
        @(posedge clk_i);
        cmp_in <= v;
        sleep_mode <= s;
        clk_req <= r;
    endtask : set_in

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_cyc

    function automatic logic [31:0] ctrl(input logic [1:0] h, input logic lp,
                                         input logic [1:0] e, input logic pad, input logic run);
        ctrl = (32'h1 << `CTRL_ENABLE_BIT) | (32'(h) << `CTRL_HYS_LSB)
             | (32'(lp) << `CTRL_LOWPOWER_BIT) | (32'(e) << `CTRL_EDGE_LSB)
             | (32'(pad) << `CTRL_PADOUT_BIT) | (32'(run) << `CTRL_STANDBY_BIT);
    endfunction : ctrl

    function automatic logic [31:0] mux(input logic inv, input logic p, input logic [1:0] n);
        mux = (32'(inv) << `MUX_INVERT_BIT) | (32'(p) << `MUX_POS_BIT) | (32'(n) << `MUX_NEG_LSB);
    endfunction : mux

    function automatic logic [31:0] stat(input logic f, input logic s);
        stat = (32'(f) << `STATUS_FLAG_BIT) | (32'(s) << `STATUS_STATE_BIT);
    endfunction : stat

    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        read_check(A_CTRL, 32'(`CTRL_RESET));
        read_check(A_MUX, 32'(`MUX_RESET));
        read_check(A_INTEN, 32'h0);
        read_check(A_STAT, 32'h0);
        bus_write(A_NONE, 32'hFF);
        read_check(A_NONE, 32'h0);
        // Inputs chosen before enable, enable written last
        bus_write(A_MUX, mux(1'b0, 1'b1, 2'h2));
        // Select copies trail the register by one edge
        wait_cyc(1);
        check_bit(pos_sel, 1'b1, "positive select");
        check_word(32'(neg_sel), 32'h2, "negative select");
        bus_write(A_CTRL, ctrl(2'h2, 1'b1, EDGE_RISE, 1'b1, 1'b0));
        read_check(A_CTRL, ctrl(2'h2, 1'b1, EDGE_RISE, 1'b1, 1'b0));
        check_bit(lp_sel, 1'b1, "low power");
        wait_cyc(240);
        check_bit(res_valid, 1'b0, "start-up window");
        wait_cyc(20);
        check_bit(res_valid, 1'b1, "start-up done");
        // Reference is selected; let it settle before trusting any result
        wait_cyc(`VREF_STARTUP_CYCLES);
        for (int h = 0; h < 4; h++) begin
            bus_write(A_CTRL, ctrl(h[1:0], 1'b0, EDGE_RISE, 1'b1, 1'b0));
            wait_cyc(1);
            check_word(32'(hys_sel), 32'(h), "hysteresis");
        end
        check_bit(lp_sel, 1'b0, "low power off");
        for (int i = 0; i < 8; i++) begin
            bus_write(A_MUX, mux(1'b0, i[2], i[1:0]));
            set_in(8'h1 << i, SLEEP_ACTIVE, 1'b0);
            wait_cyc(3);
            check_bit(ev, 1'b1, "event high");
            check_bit(pad_out, 1'b1, "pad high");
            check_bit(pad_oe, 1'b1, "pad enabled");
            set_in(~(8'h1 << i), SLEEP_ACTIVE, 1'b0);
            wait_cyc(3);
            check_bit(ev, 1'b0, "event low");
        end
        bus_write(A_MUX, mux(1'b1, 1'b0, 2'h0));
        set_in(8'h00, SLEEP_ACTIVE, 1'b0);
        wait_cyc(3);
        check_bit(ev, 1'b1, "inverted event");
        check_bit(pad_out, 1'b1, "inverted pad");
        bus_write(A_MUX, mux(1'b0, 1'b0, 2'h0));
        for (int k = 0; k < 4; k++) begin
            bus_write(A_CTRL, ctrl(2'h0, 1'b0, md[k], 1'b1, 1'b0));
            bus_write(A_STAT, 32'h1);
            read_check(A_STAT, stat(1'b0, 1'b0));
            set_in(8'h01, SLEEP_ACTIVE, 1'b0);
            wait_cyc(8);
            read_check(A_STAT, stat(md[k] == EDGE_BOTH || md[k] == EDGE_RISE, 1'b1));
            bus_write(A_STAT, 32'h1);
            set_in(8'h00, SLEEP_ACTIVE, 1'b0);
            wait_cyc(8);
            read_check(A_STAT, stat(md[k] == EDGE_BOTH || md[k] == EDGE_FALL, 1'b0));
            bus_write(A_STAT, 32'h1);
        end
        bus_write(A_CTRL, ctrl(2'h0, 1'b0, EDGE_RISE, 1'b1, 1'b0));
        bus_write(A_INTEN, 32'h1);
        check_bit(irq, 1'b0, "no request without flag");
        set_in(8'h01, SLEEP_ACTIVE, 1'b0);
        wait_cyc(8);
        check_bit(irq, 1'b1, "request");
        set_in(8'h00, SLEEP_ACTIVE, 1'b0);
        wait_cyc(8);
        check_bit(irq, 1'b1, "request held");
        bus_write(A_STAT, 32'h0);
        read_check(A_STAT, stat(1'b1, 1'b0));
        bus_write(A_INTEN, 32'h0);
        wait_cyc(2);
        check_bit(irq, 1'b0, "request masked");
        bus_write(A_INTEN, 32'h1);
        wait_cyc(2);
        check_bit(irq, 1'b1, "request unmasked");
        bus_write(A_STAT, 32'h1);
        wait_cyc(2);
        check_bit(irq, 1'b0, "request cleared");
        // Idle sleep with pad output off
        bus_write(A_CTRL, ctrl(2'h0, 1'b0, EDGE_RISE, 1'b0, 1'b0));
        set_in(8'h01, SLEEP_IDLE, 1'b0);
        wait_cyc(8);
        check_bit(ev, 1'b1, "idle event");
        check_bit(pad_oe, 1'b0, "pad off");
        check_bit(pad_out, 1'b0, "pad value off");
        read_check(A_STAT, stat(1'b1, 1'b1));
        set_in(8'h00, SLEEP_IDLE, 1'b0);
        bus_write(A_STAT, 32'h1);
        // Standby with run: outputs live, status frozen while clock unrequested
        bus_write(A_CTRL, ctrl(2'h0, 1'b0, EDGE_RISE, 1'b1, 1'b1));
        set_in(8'h01, SLEEP_STANDBY, 1'b0);
        wait_cyc(6);
        check_bit(ev, 1'b1, "standby event");
        check_bit(pad_out, 1'b1, "standby pad");
        read_check(A_STAT, stat(1'b0, 1'b0));
        check_bit(irq, 1'b0, "standby request");
        set_in(8'h00, SLEEP_STANDBY, 1'b0);
        wait_cyc(6);
        check_bit(ev, 1'b0, "standby event low");
        set_in(8'h01, SLEEP_STANDBY, 1'b1);
        wait_cyc(8);
        read_check(A_STAT, stat(1'b1, 1'b1));
        check_bit(irq, 1'b1, "standby request live");
        set_in(8'h00, SLEEP_STANDBY, 1'b1);
        wait_cyc(8);
        bus_write(A_STAT, 32'h1);
        set_in(8'h01, SLEEP_POWERDOWN, 1'b1);
        wait_cyc(4);
        check_bit(ana_en, 1'b0, "power-down analog");
        check_bit(pad_oe, 1'b0, "power-down pad");
        check_bit(ev, 1'b0, "power-down event");
        bus_write(A_CTRL, ctrl(2'h0, 1'b0, EDGE_RISE, 1'b1, 1'b0));
        set_in(8'h01, SLEEP_STANDBY, 1'b0);
        wait_cyc(4);
        check_bit(ana_en, 1'b0, "standby analog");
        check_bit(ev, 1'b0, "standby stopped");
        set_in(8'h00, SLEEP_ACTIVE, 1'b0);
        wait_cyc(260);
        check_bit(ana_en, 1'b1, "awake analog");
        check_bit(res_valid, 1'b1, "awake valid");
        wrap_up();
    end
endmodule : comparator_control_test
